// *** src/fpic_defs.vh ***
/*
 * register offsets, field positions, reset values and operation codes of the
 * flash protection, interrupt and chip-select block.
 * assumes: included by bare name from the block's design files.
 */
`ifndef FPIC_DEFS_VH
`define FPIC_DEFS_VH

// byte offsets on the register bus, then of the memory operation word, which has its own port
`define FPIC_OFF_STATUS     4'h0
`define FPIC_OFF_STATUS_CLR 4'h4
`define FPIC_OFF_MASK       4'h8
`define FPIC_OFF_SELECT     4'hc
`define FPIC_OFF_MEM_OP     4'h0
`define FPIC_OFF_MEM_OP_HI  4'h1

// status / mask bit positions
`define FPIC_BIT_ILL_ERASE  0
`define FPIC_BIT_ILL_WRITE  1

// memory operation field layout
`define FPIC_OP_LSB         0
`define FPIC_OP_MSB         1
`define FPIC_SECT_LSB       8
`define FPIC_SECT_MSB       23
`define FPIC_TB_BIT         12
`define FPIC_BP_MSB         11
`define FPIC_BP_LSB         8

// memory operation codes
`define FPIC_OP_NONE        2'h0
`define FPIC_OP_BULK        2'h1
`define FPIC_OP_SECT_ERASE  2'h2
`define FPIC_OP_PROTECT     2'h3

// reset values
`define FPIC_RST_STATUS     2'h0
`define FPIC_RST_MASK       2'h0
`define FPIC_RST_SELECT     3'h0
`define FPIC_RST_CHIP_SEL   3'h1
`define FPIC_RST_SECTOR     16'h0000

// one sector spans this many byte addresses (log2)
`define FPIC_SECT_SHIFT     16

`endif

// *** src/fpic_sector_check.v ***
/*
 * protection check: decides whether a sector falls inside the region that
 * the block-protect level and top/bottom selector cover.
 * assumes: sector count of the attached device is a power of two given as
 * log2 on dens_log2 (5 for 32 sectors up to 11 for 2048).
 */
`timescale 1ns/1ps
`include "fpic_defs.vh"

module fpic_sector_check
(
    // protection setting
    input  wire [3:0]  block_protect_level,
    input  wire        top_bottom_selector,
    // device density
    input  wire [3:0]  dens_log2,
    // sector under test
    input  wire [15:0] sector,
    // result
    output reg         protected_hit
);
    reg [15:0] span;
    reg [15:0] limit;
    reg [4:0]  shift;

    // level n protects 2^(n-1) sectors, at most the whole device; level 0 protects none
    always @*
    begin
        span          = 16'h0000;
        limit         = 16'h0001 << dens_log2;
        shift         = 5'h00;
        protected_hit = 1'b0;
        if (block_protect_level != 4'h0)
        begin
            shift = {1'b0, block_protect_level} - 5'h01;
            span  = 16'h0001 << shift;
            if (span > limit)
                span = limit;
            if (top_bottom_selector)
                protected_hit = (sector < span);
            else
                protected_hit = (sector >= (limit - span)) && (sector < limit);
        end
    end
endmodule

// *** src/fpic_top.v ***
/*
 * flash protection-violation interrupt, chip select and sector operand block,
 * with an axi4-lite register slave and a command handoff to the serial engine.
 * assumes: a serial flash engine that takes op_valid/op_ready handshakes,
 * and reports write requests to check via wr_req/wr_addr; one clock.
 */
// Added by the designer: the address map and the AXI4-Lite slave port.
// Summary of operation
// R1 - write to protected sector is cancelled and sets status bit 1, write-one clears
// R2 - erase of protected sector is cancelled and sets status bit 0, write-one clears; no flag here if it arrives while a command waits
// R3 - mask bit 1 enables the illegal-write interrupt, resets to zero
// R4 - mask bit 0 enables the illegal-erase interrupt, resets to zero
// R5 - interrupt is high while any status bit and its mask bit are set; irq here is registered and follows one cycle later
// R6 - software writes only bit 2 of the select register to choose chip three
// R7 - software writes only bit 1 of the select register to choose chip two
// R8 - chip one chosen when bits 2 and 1 are zero; select is write-only, resets zero
// R9 - sector field bits 23 to 8 take a multi-sector protect combination
// R10 - software keeps sector field bits 13 to 23 zero for protect
// R11 - bit 12 is top/bottom, bits 11 to 8 are protect levels high first
// R12 - sector erase acts on one sector of 65536 addresses
// R13 - software loads the binary sector index for an erase
// R14 - software keeps sector index inside the attached device's range
// R15 - op code 3 writes the sector field into the flash protect bits
// R16 - op code 2 erases a sector, 1 erases all, 0 does nothing
`timescale 1ns/1ps
`include "fpic_defs.vh"

module fpic_top
(
    // clock and reset
    input  wire        clk,
    input  wire        nrst,
    // axi4-lite write address
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // memory operation command register (separate write port)
    input  wire [31:0] mem_op_wdata,
    input  wire        mem_op_wr,
    // device density as log2 of the sector count
    input  wire [3:0]  dens_log2,
    // command to serial engine
    output reg  [1:0]  op_code,
    output reg  [15:0] op_operand,
    output reg  [31:0] op_addr,
    output reg         op_valid,
    input  wire        op_ready,
    // write requests from the data path, checked before issue
    input  wire        wr_req,
    input  wire [31:0] wr_addr,
    output wire        wr_grant,
    output wire        wr_cancel,
    // chip selects, one-hot
    output reg  [2:0]  chip_select,
    // interrupt
    output reg         irq
);
    reg  [1:0]  protect_violation_status;
    reg  [1:0]  protect_violation_mask;
    reg  [2:0]  flash_device_select;
    reg  [3:0]  block_protect_level;
    reg         top_bottom_selector;

    reg  [3:0]  aw_addr;
    reg         aw_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         w_held;

    wire        erase_hit;
    wire        write_hit;
    wire        erase_cancel;
    wire        wr_event;
    wire        erase_event;
    wire        clr_write;
    wire        clr_erase;
    wire        wr_do;
    wire [15:0] wr_sector;
    wire [1:0]  cmd_op;

    // the mem-op register word decoding is used for both the protect and erase paths
    function [15:0] sect_field;
        input [31:0] word;
        begin
            sect_field = word[`FPIC_SECT_MSB:`FPIC_SECT_LSB];
        end
    endfunction

    function is_addr;
        input [3:0] a;
        input [3:0] off;
        begin
            is_addr = (a[3:2] == off[3:2]);
        end
    endfunction

    // ---------------- axi4-lite write path ----------------
    // address and data are taken in either order; response follows both
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_do         = aw_held && w_held && !s_axi_bvalid;

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            aw_held      <= 1'b0;
            aw_addr      <= 4'h0;
            w_held       <= 1'b0;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_do)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // the status register is read-only; its clear lives at its own offset
                s_axi_bresp  <= is_addr(aw_addr, `FPIC_OFF_STATUS) ? 2'h2 : 2'h0;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    assign clr_write = wr_do && is_addr(aw_addr, `FPIC_OFF_STATUS_CLR) && w_strb[0]
                       && w_data[`FPIC_BIT_ILL_WRITE];
    assign clr_erase = wr_do && is_addr(aw_addr, `FPIC_OFF_STATUS_CLR) && w_strb[0]
                       && w_data[`FPIC_BIT_ILL_ERASE];

    // mask and chip select registers
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            protect_violation_mask <= `FPIC_RST_MASK;   // [R3] [R4]
            flash_device_select    <= `FPIC_RST_SELECT; // [R8]
        end
        else if (wr_do && w_strb[0])
        begin
            if (is_addr(aw_addr, `FPIC_OFF_MASK))
                protect_violation_mask <= w_data[1:0];  // [R3] [R4]
            if (is_addr(aw_addr, `FPIC_OFF_SELECT))
                flash_device_select <= w_data[2:0];
        end
    end

    // chip one unless bit 2 or bit 1 is set; bit 2 takes priority if both are
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            chip_select <= `FPIC_RST_CHIP_SEL;
        else if (flash_device_select[2])
            chip_select <= 3'h4;
        else if (flash_device_select[1])
            chip_select <= 3'h2;
        else
            chip_select <= 3'h1; // [R8]
    end

    // ---------------- axi4-lite read path ----------------
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'h0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            s_axi_rdata  <= 32'h00000000;
            if (is_addr(s_axi_araddr, `FPIC_OFF_STATUS))
                s_axi_rdata <= {30'h0, protect_violation_status};
            else if (is_addr(s_axi_araddr, `FPIC_OFF_MASK))
                s_axi_rdata <= {30'h0, protect_violation_mask};
            else
                s_axi_rresp <= 2'h2; // clear and select are write-only
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ---------------- memory operation command ----------------
    assign cmd_op = mem_op_wdata[`FPIC_OP_MSB:`FPIC_OP_LSB];

    // protect bits are held locally so erases and writes can be checked
    // without a round trip to the flash status register
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            block_protect_level <= 4'h0;
            top_bottom_selector <= 1'b0;
            op_code             <= `FPIC_OP_NONE;
            op_operand          <= 16'h0000;
            op_addr             <= 32'h00000000;
            op_valid            <= 1'b0;
        end
        else
        begin
            if (op_valid && op_ready)
                op_valid <= 1'b0;
            // a new command is ignored while one is still waiting for the engine
            if (mem_op_wr && !op_valid)
            begin
                case (cmd_op)
                    `FPIC_OP_PROTECT:
                    begin
                        // only tb and bp3..bp0 are kept locally; upper bits pass to the engine in op_operand
                        top_bottom_selector <= mem_op_wdata[`FPIC_TB_BIT]; // [R11]
                        block_protect_level <= mem_op_wdata[`FPIC_BP_MSB:`FPIC_BP_LSB]; // [R11]
                        op_code    <= cmd_op;
                        op_operand <= sect_field(mem_op_wdata); // [R15] [R9]
                        op_addr    <= 32'h00000000;
                        op_valid   <= 1'b1;
                    end
                    `FPIC_OP_SECT_ERASE:
                    begin
                        if (!erase_hit)
                        begin
                            op_code    <= cmd_op;
                            op_operand <= sect_field(mem_op_wdata);
                            // one sector, addressed at its first byte
                            op_addr    <= {sect_field(mem_op_wdata), 16'h0000}; // [R12] [R16]
                            op_valid   <= 1'b1;
                        end
                    end
                    `FPIC_OP_BULK:
                    begin
                        // a bulk erase would hit any protected sector
                        if (block_protect_level == 4'h0)
                        begin
                            op_code    <= cmd_op; // [R16]
                            op_operand <= 16'h0000;
                            op_addr    <= 32'h00000000;
                            op_valid   <= 1'b1;
                        end
                    end
                    default:
                    begin
                        op_code <= op_code; // [R16]
                    end
                endcase
            end
        end
    end

    fpic_sector_check u_erase_check
    (
        .block_protect_level (block_protect_level),
        .top_bottom_selector (top_bottom_selector),
        .dens_log2           (dens_log2),
        .sector              (sect_field(mem_op_wdata)),
        .protected_hit       (erase_hit)
    );

    // sector index of a write: one sector per 64 KiB of address space
    // writes beyond the attached device's range are never flagged
    assign wr_sector = wr_addr[31:`FPIC_SECT_SHIFT];

    fpic_sector_check u_write_check
    (
        .block_protect_level (block_protect_level),
        .top_bottom_selector (top_bottom_selector),
        .dens_log2           (dens_log2),
        .sector              (wr_sector),
        .protected_hit       (write_hit)
    );

    // a command that arrives while another waits is dropped without a flag
    assign erase_cancel = mem_op_wr && !op_valid && (((cmd_op == `FPIC_OP_SECT_ERASE) && erase_hit)
                          || ((cmd_op == `FPIC_OP_BULK) && (block_protect_level != 4'h0)));
    assign erase_event  = erase_cancel;          // [R2]
    assign wr_event     = wr_req && write_hit;   // [R1]
    assign wr_cancel    = wr_event;
    assign wr_grant     = wr_req && !write_hit;

    // ---------------- violation status ----------------
    // a new violation in the clearing cycle keeps its flag
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            protect_violation_status <= `FPIC_RST_STATUS;
        else
        begin
            if (wr_event)
                protect_violation_status[`FPIC_BIT_ILL_WRITE] <= 1'b1; // [R1]
            else if (clr_write)
                protect_violation_status[`FPIC_BIT_ILL_WRITE] <= 1'b0; // [R1]
            if (erase_event)
                protect_violation_status[`FPIC_BIT_ILL_ERASE] <= 1'b1; // [R2]
            else if (clr_erase)
                protect_violation_status[`FPIC_BIT_ILL_ERASE] <= 1'b0; // [R2]
        end
    end

    // registered so the pin sees no decode glitch; it trails the status by one cycle
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            irq <= 1'b0;
        else
            irq <= |(protect_violation_status & protect_violation_mask); // [R5] [R3] [R4]
    end
endmodule

// *** verification/fpic_checker.sv ***
/* port checker for the protection, interrupt and chip-select block.
   assumes: bound to fpic_top; one clock, async active-low reset. */
`timescale 1ns/1ps
module fpic_checker
(
    // clock and reset
    input logic        clk,
    input logic        nrst,
    // command side
    input logic [31:0] mem_op_wdata,
    input logic        mem_op_wr,
    input logic [1:0]  op_code,
    input logic [15:0] op_operand,
    input logic [31:0] op_addr,
    input logic        op_valid,
    input logic        op_ready,
    // write check, selects, interrupt
    input logic        wr_req,
    input logic        wr_grant,
    input logic        wr_cancel,
    input logic [2:0]  chip_select,
    input logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    grant_or_cancel_a: assert property (wr_req == (wr_grant || wr_cancel) && !(wr_grant && wr_cancel))
        else $error("write grant and cancel disagree");
    cmd_hold_a: assert property (op_valid && !op_ready |=> op_valid && $stable(op_addr) && $stable(op_code))
        else $error("command dropped before acceptance");
    erase_address_a: assert property (op_valid && op_code == 2'h2 |-> op_addr == {op_operand, 16'h0000})
        else $error("erase address not sector times 65536");
    no_idle_cmd_a: assert property (!(op_valid && op_code == 2'h0))
        else $error("idle code issued as command");
    select_onehot_a: assert property ($onehot(chip_select))
        else $error("chip select not one-hot");
    select_reset_a: assert property ($rose(nrst) |-> chip_select == 3'h1)
        else $error("first chip not selected after reset");
    protect_issue_a: assert property (mem_op_wr && !op_valid && mem_op_wdata[1:0] == 2'h3 |=>
        op_valid && op_code == 2'h3 && op_operand == $past(mem_op_wdata[23:8]))
        else $error("protect command not issued with its sector field");
    irq_reset_a: assert property ($rose(nrst) |-> !irq)
        else $error("interrupt high after reset");
    cover property (wr_cancel);
    cover property (op_valid && op_ready && op_code == 2'h2);
    cover property ($rose(irq));
endmodule

bind fpic_top fpic_checker chk (.clk(clk), .nrst(nrst), .mem_op_wdata(mem_op_wdata), .mem_op_wr(mem_op_wr),
    .op_code(op_code), .op_operand(op_operand), .op_addr(op_addr), .op_valid(op_valid), .op_ready(op_ready),
    .wr_req(wr_req), .wr_grant(wr_grant), .wr_cancel(wr_cancel), .chip_select(chip_select), .irq(irq));

// *** verification/fpic_engine_model.sv ***
/* model of the serial flash engine that takes commands from the block.
   assumes: same clock and reset as the block; slow stretches each accept. */
`timescale 1ns/1ps
module fpic_engine_model
(
    // clock and reset
    input  logic       clk,
    input  logic       nrst,
    // command handshake
    input  logic       op_valid,
    output logic       op_ready,
    // pacing and bookkeeping
    input  logic       slow,
    output logic [7:0] taken
);
    logic [1:0] wait_cnt;
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            op_ready <= 1'b0;
            wait_cnt <= 2'h0;
            taken <= 8'h00;
        end
        else if (op_valid && op_ready)
        begin
            op_ready <= 1'b0;
            wait_cnt <= 2'h0;
            taken <= taken + 8'h01;
        end
        else if (op_valid && (!slow || wait_cnt == 2'h3))
            op_ready <= 1'b1;
        else if (op_valid)
            wait_cnt <= wait_cnt + 2'h1;
    end
endmodule

// *** verification/tb_flash_protect_irq_chip_select.sv ***
/* self-checking bench for fpic_top with an engine model.
   assumes: 4 ns clock, 32 sectors attached (dens_log2 = 5). */
`timescale 1ns/1ps
module tb_flash_protect_irq_chip_select;
    logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready, mem_op_wr, wr_req, slow;
    logic [3:0]  awaddr, araddr;
    logic [31:0] wdata, mem_op_wdata, wr_addr;
    wire         awready, wready, bvalid, arready, rvalid, op_valid, op_ready, wr_grant, wr_cancel, irq;
    wire  [1:0]  bresp, rresp, op_code;
    wire  [31:0] rdata, op_addr;
    wire  [15:0] op_operand;
    wire  [2:0]  chip_select;
    wire  [7:0]  taken;
    integer      errors, checks_done, cycles;
    fpic_top dut (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .mem_op_wdata(mem_op_wdata), .mem_op_wr(mem_op_wr), .dens_log2(4'h5),
        .op_code(op_code), .op_operand(op_operand), .op_addr(op_addr), .op_valid(op_valid), .op_ready(op_ready),
        .wr_req(wr_req), .wr_addr(wr_addr), .wr_grant(wr_grant), .wr_cancel(wr_cancel),
        .chip_select(chip_select), .irq(irq));
    fpic_engine_model eng (.clk(clk), .nrst(nrst), .op_valid(op_valid), .op_ready(op_ready), .slow(slow),
        .taken(taken));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // a hang anywhere ends here and counts against the run
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            errors = errors + 1;
            wrap_up;
        end
    end
    task wrap_up;
        begin
            $display("checks %0d errors %0d", checks_done, errors);
            if (errors == 0 && checks_done > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e)
            begin
                errors = errors + 1;
                $display("mismatch %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // handshakes are judged at the falling edge, where values from the last rise are settled
    task axi_wr(input [3:0] a, input [31:0] d, input [1:0] er);
        logic aw, w, b;
        logic [1:0] br;
        begin
            @(posedge clk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            b = 1'b0;
            while (!b)
            begin
                @(negedge clk);
                aw = awvalid && awready;
                w = wvalid && wready;
                b = bvalid;
                br = bresp;
                @(posedge clk);
                if (aw)
                    awvalid <= 1'b0;
                if (w)
                    wvalid <= 1'b0;
            end
            bready <= 1'b0;
            // registered outputs fed by the write change on this edge
            @(negedge clk);
            chk("bresp", er, br);
        end
    endtask
    task axi_rd(input [3:0] a, input [31:0] ed, input [1:0] er);
        logic ar, r;
        logic [31:0] rd;
        logic [1:0] rr;
        begin
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            r = 1'b0;
            while (!r)
            begin
                @(negedge clk);
                ar = arvalid && arready;
                r = rvalid;
                rd = rdata;
                rr = rresp;
                @(posedge clk);
                if (ar)
                    arvalid <= 1'b0;
            end
            rready <= 1'b0;
            chk("rdata", ed, rd);
            chk("rresp", er, rr);
        end
    endtask
    task cmd(input [31:0] w, input issue);
        begin
            @(posedge clk);
            mem_op_wdata <= w;
            mem_op_wr <= 1'b1;
            @(posedge clk);
            mem_op_wr <= 1'b0;
            @(negedge clk);
            chk("op_valid", issue, op_valid);
            if (issue)
            begin
                chk("op_code", w[1:0], op_code);
                chk("op_operand", w[23:8], op_operand);
                if (w[1:0] == 2'h2)
                    chk("op_addr", {w[23:8], 16'h0000}, op_addr);
                while (op_valid)
                    @(negedge clk);
            end
        end
    endtask
    task wr_chk(input [31:0] adr, input cancel);
        begin
            @(posedge clk);
            wr_req <= 1'b1;
            wr_addr <= adr;
            @(negedge clk);
            chk("wr_cancel", cancel, wr_cancel);
            chk("wr_grant", !cancel, wr_grant);
            @(posedge clk);
            wr_req <= 1'b0;
        end
    endtask
    task t_regs;
        begin
            chk("chip_select", 3'h1, chip_select);
            chk("irq", 1'b0, irq);
            axi_rd(4'h0, 32'h0, 2'h0);
            axi_rd(4'h8, 32'h0, 2'h0);
            axi_rd(4'h4, 32'h0, 2'h2);
            axi_rd(4'hc, 32'h0, 2'h2);
            axi_wr(4'h0, 32'h3, 2'h2);
            axi_wr(4'h8, 32'h3, 2'h0);
            axi_rd(4'h8, 32'h3, 2'h0);
            axi_wr(4'h8, 32'h0, 2'h0);
            $display("test regs done");
        end
    endtask
    task t_select;
        begin
            axi_wr(4'hc, 32'h4, 2'h0);
            chk("chip_select", 3'h4, chip_select);
            axi_wr(4'hc, 32'h2, 2'h0);
            chk("chip_select", 3'h2, chip_select);
            axi_wr(4'hc, 32'h0, 2'h0);
            chk("chip_select", 3'h1, chip_select);
            $display("test select done");
        end
    endtask
    task t_protect;
        begin
            cmd(32'h00001203, 1'b1);
            slow <= 1'b1;
            cmd(32'h00001f02, 1'b1);
            cmd(32'h00000102, 1'b0);
            axi_rd(4'h0, 32'h1, 2'h0);
            chk("irq", 1'b0, irq);
            axi_wr(4'h8, 32'h1, 2'h0);
            chk("irq", 1'b1, irq);
            axi_wr(4'h4, 32'h1, 2'h0);
            axi_rd(4'h0, 32'h0, 2'h0);
            chk("irq", 1'b0, irq);
            $display("test protect done");
        end
    endtask
    task t_write;
        begin
            axi_wr(4'h8, 32'h2, 2'h0);
            wr_chk(32'h0001ffff, 1'b1);
            wr_chk(32'h00020000, 1'b0);
            axi_rd(4'h0, 32'h2, 2'h0);
            chk("irq", 1'b1, irq);
            axi_wr(4'h4, 32'h2, 2'h0);
            chk("irq", 1'b0, irq);
            $display("test write done");
        end
    endtask
    task t_bulk;
        begin
            cmd(32'h00000001, 1'b0);
            axi_rd(4'h0, 32'h1, 2'h0);
            axi_wr(4'h4, 32'h1, 2'h0);
            cmd(32'h00000000, 1'b0);
            cmd(32'h00000003, 1'b1);
            cmd(32'h00000001, 1'b1);
            axi_rd(4'h0, 32'h0, 2'h0);
            chk("taken", 8'h04, taken);
            $display("test bulk done");
        end
    endtask
    initial
    begin
        {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata, mem_op_wdata, wr_addr} = '0;
        {mem_op_wr, wr_req, slow, nrst} = '0;
        errors = 0;
        checks_done = 0;
        cycles = 0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        t_regs;
        t_select;
        t_protect;
        t_write;
        t_bulk;
        wrap_up;
    end
endmodule
